// >>> common/mpr_pkg.sv
package mpr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ROUTE_OFS = 8'h8C;
  localparam logic [7:0] GPOUT_OFS = 8'h8B;
  localparam logic [7:0] GPIN_OFS = 8'h8A;
  localparam logic [7:0] GPSTS_OFS = 8'h88;
  localparam logic [7:0] LOAD_OFS = 8'hF0;
  localparam logic [31:0] ROUTE_RESET = 32'h0000_1000;
  localparam logic [31:0] ROUTE_MASK = 32'h0FFF_FFFF;
  localparam int SEL_W = 4;
  localparam int PIN_N = 7;
  localparam int GP_N = 5;
  // ----------------------------------------
  // selector codes
  // ----------------------------------------
  localparam logic [3:0] SEL_GPIN = 4'h0;
  localparam logic [3:0] SEL_GPOUT = 4'h1;
  localparam logic [3:0] SEL_CODE2 = 4'h2;
  localparam logic [3:0] SEL_VSTAT = 4'h6;
  localparam logic [3:0] SEL_VSEL0 = 4'h7;
  localparam logic [3:0] SEL_PWM = 4'h8;
  localparam logic [3:0] SEL_LED_A1 = 4'hC;
  localparam logic [3:0] SEL_LEDB = 4'hD;
  localparam logic [3:0] SEL_EVENT = 4'hE;
  localparam logic [3:0] SEL_IRQHI = 4'hF;
endpackage

// >>> verilog/mpr_sync.sv
`timescale 1ns/10ps
module mpr_sync #(
  parameter int W = 7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // meta feeds only q
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // mpr_sync

// >>> verilog/mpr_pin_cell.sv
`timescale 1ns/10ps
module mpr_pin_cell #(
  parameter int PIN = 0
) (
  // selector
  input wire logic [3:0] sel,
  // internal sources
  input wire logic [15:0] irq,
  input wire logic gp_out,
  input wire logic clock_run_line,
  input wire logic serial_interrupt_line,
  input wire logic pc_request_line,
  input wire logic video_status_line,
  input wire logic video_select_0,
  input wire logic audio_pwm_out,
  input wire logic led_drive_a1,
  input wire logic led_drive_a2,
  input wire logic socket_led,
  input wire logic event_output,
  input wire logic ring_indicate_output,
  input wire logic test_output_mux,
  input wire logic inta_line,
  // pin drive
  output logic drv,
  output logic oe
);
  always_comb begin
    drv = 1'b0;
    oe = 1'b1;
    case (PIN)
      6, 3: begin
        if (sel == 4'h0) begin
          oe = 1'b0; // [RULE_15]
        end else if (sel == 4'h1) begin
          drv = (PIN == 6) ? clock_run_line : serial_interrupt_line; // [RULE_01] [RULE_04]
        end else begin
          drv = irq[sel]; // [RULE_01] [RULE_04]
        end
      end
      5, 4: begin
        case (sel)
          mpr_pkg::SEL_GPOUT: drv = gp_out; // [RULE_14]
          4'h4: drv = irq[4];
          mpr_pkg::SEL_PWM: drv = audio_pwm_out;
          4'h9: drv = irq[9];
          mpr_pkg::SEL_LED_A1: drv = (PIN == 5) ? led_drive_a1 : ring_indicate_output; // [RULE_03]
          mpr_pkg::SEL_LEDB: drv = socket_led; // [RULE_02] [RULE_03]
          mpr_pkg::SEL_EVENT: drv = event_output;
          mpr_pkg::SEL_IRQHI: drv = irq[15];
          default: oe = 1'b0; // [RULE_15]
        endcase
      end
      2: begin
        case (sel)
          mpr_pkg::SEL_GPOUT: drv = gp_out; // [RULE_14]
          mpr_pkg::SEL_CODE2: drv = pc_request_line; // [RULE_05]
          4'h3, 4'h4, 4'h5: drv = irq[sel];
          mpr_pkg::SEL_VSTAT: drv = video_status_line;
          mpr_pkg::SEL_VSEL0: drv = video_select_0;
          mpr_pkg::SEL_LED_A1: drv = ring_indicate_output;
          mpr_pkg::SEL_LEDB: drv = test_output_mux;
          mpr_pkg::SEL_EVENT: drv = event_output;
          mpr_pkg::SEL_IRQHI: drv = irq[7]; // [RULE_05]
          default: oe = 1'b0; // [RULE_15]
        endcase
      end
      default: begin
        // pins 1 and 0 share the upper half of the table
        case (sel)
          mpr_pkg::SEL_PWM: drv = audio_pwm_out; // [RULE_06] [RULE_07]
          4'h9, 4'hA, 4'hB: drv = irq[sel];
          mpr_pkg::SEL_LED_A1: drv = led_drive_a1;
          mpr_pkg::SEL_LEDB: drv = led_drive_a2;
          mpr_pkg::SEL_EVENT: drv = event_output;
          mpr_pkg::SEL_IRQHI: drv = irq[15];
          default: begin
            if (PIN == 0) begin
              case (sel)
                mpr_pkg::SEL_GPOUT: drv = gp_out; // [RULE_14]
                mpr_pkg::SEL_CODE2: drv = inta_line; // [RULE_07]
                4'h3, 4'h4, 4'h5: drv = irq[sel];
                mpr_pkg::SEL_VSTAT: drv = video_status_line;
                mpr_pkg::SEL_VSEL0: drv = video_select_0;
                default: oe = 1'b0; // [RULE_15]
              endcase
            end else begin
              oe = 1'b0; // [RULE_15]
            end
          end
        endcase
      end
    endcase
  end
endmodule // mpr_pin_cell

// >>> verilog/mpr_router.sv
`timescale 1ns/10ps
// Operation
// [RULE_01] pin 6 selector bits 27-24: clock-run at 1, IRQ2..IRQ15 at 2..15
// [RULE_02] pin 5 selector bits 23-20: gp in/out 4, IRQs, pwm, leds, event
// [RULE_03] pin 4 selector bits 19-16: gp in/out 3, IRQs, pwm, ring, led, event
// [RULE_04] pin 3 selector bits 15-12: serial interrupt at 1, IRQ by code value
// [RULE_05] pin 2 selector bits 11-8: gp 2, pc request, IRQs, video, ring, test
// [RULE_06] pin 1 selector bits 7-4: pwm, IRQ9-11, leds A1 A2, event, IRQ15
// [RULE_07] pin 0 selector bits 3-0: full sixteen-code table incl. interrupt A
// [RULE_08] bits 31-28 of the routing register always read zero
// [RULE_09] selectors cleared only by global reset, kept over other resets
// [RULE_10] routing contents may be loaded from serial eeprom after reset
// [RULE_11] software programs routing once at power-on, then leaves it
// [RULE_12] routing register reads 0x00001000 after reset
// [RULE_13] general input status flag sets on sampled level change
// [RULE_14] general output pin drives matching output register bit
// [RULE_15] input or reserved selection disables the pin driver
module mpr_router (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic global_reset_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // eeprom preload
  input wire logic eeprom_load,
  input wire logic [31:0] eeprom_data,
  // internal sources
  input wire logic [15:0] irq,
  input wire logic clock_run_line,
  input wire logic serial_interrupt_line,
  input wire logic pc_request_line,
  input wire logic video_status_line,
  input wire logic video_select_0,
  input wire logic audio_pwm_out,
  input wire logic led_drive_a1,
  input wire logic led_drive_a2,
  input wire logic socket_led,
  input wire logic event_output,
  input wire logic ring_indicate_output,
  input wire logic test_output_mux,
  input wire logic inta_line,
  // pins
  input wire logic [6:0] multi_pin_in,
  output logic [6:0] multi_pin_out,
  output logic [6:0] multi_pin_oe,
  // general input levels
  output logic [4:0] general_input
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] route;
  logic [4:0] gp_out_reg;
  logic [4:0] gp_status;
  logic [4:0] gp_last;
  logic [6:0] pin_sync;
  logic [4:0] gp_sample;
  logic [4:0] gp_is_in;
  logic [4:0] gp_change;
  logic [6:0] pin_drv;
  logic [6:0] pin_oe;
  logic [6:0][3:0] sel;
  logic [6:0] gp_out_pin;
  logic wr_route;

  // pin index feeding each general input/output bit; bit 1 has no pin here
  function automatic int gp_pin(input int b);
    case (b)
      0: gp_pin = 0;
      2: gp_pin = 2;
      3: gp_pin = 4;
      4: gp_pin = 5;
      default: gp_pin = -1;
    endcase
  endfunction

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  // global reset only: a function reset must not fake a level change
  mpr_sync #(.W(7)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(global_reset_n),
    .clk_en(clk_en),
    .d(multi_pin_in),
    .q(pin_sync)
  );

  // ----------------------------------------
  // routing register
  // ----------------------------------------
  assign wr_route = reg_wr && (reg_addr == mpr_pkg::ROUTE_OFS);

  // global reset only: function resets do not touch routing
  always_ff @(posedge ref_clk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      route <= mpr_pkg::ROUTE_RESET; // [RULE_09] [RULE_12]
    end else if (clk_en) begin
      if (wr_route) begin
        route <= reg_wdata & mpr_pkg::ROUTE_MASK; // [RULE_08]
      end else if (eeprom_load) begin
        route <= eeprom_data & mpr_pkg::ROUTE_MASK; // [RULE_10]
      end
    end
  end

  // ----------------------------------------
  // general purpose bits
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      gp_out_reg <= '0;
    end else if (clk_en && reg_wr && reg_addr == mpr_pkg::GPOUT_OFS) begin
      gp_out_reg <= reg_wdata[4:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < mpr_pkg::PIN_N; g++) begin : g_pin
      assign sel[g] = route[g*4 +: 4];
      if (g == 0) begin : g_o0
        assign gp_out_pin[g] = gp_out_reg[0];
      end else if (g == 2) begin : g_o2
        assign gp_out_pin[g] = gp_out_reg[2];
      end else if (g == 4) begin : g_o4
        assign gp_out_pin[g] = gp_out_reg[3];
      end else if (g == 5) begin : g_o5
        assign gp_out_pin[g] = gp_out_reg[4];
      end else begin : g_ox
        assign gp_out_pin[g] = 1'b0;
      end
      mpr_pin_cell #(.PIN(g)) u_cell (
        .sel(sel[g]),
        .irq(irq),
        .gp_out(gp_out_pin[g]), // [RULE_14]
        .clock_run_line(clock_run_line),
        .serial_interrupt_line(serial_interrupt_line),
        .pc_request_line(pc_request_line),
        .video_status_line(video_status_line),
        .video_select_0(video_select_0),
        .audio_pwm_out(audio_pwm_out),
        .led_drive_a1(led_drive_a1),
        .led_drive_a2(led_drive_a2),
        .socket_led(socket_led),
        .event_output(event_output),
        .ring_indicate_output(ring_indicate_output),
        .test_output_mux(test_output_mux),
        .inta_line(inta_line),
        .drv(pin_drv[g]),
        .oe(pin_oe[g])
      );
    end
    for (g = 0; g < mpr_pkg::GP_N; g++) begin : g_gp
      if (gp_pin(g) >= 0) begin : g_on
        assign gp_sample[g] = pin_sync[gp_pin(g)];
        assign gp_is_in[g] = (sel[gp_pin(g)] == mpr_pkg::SEL_GPIN);
      end else begin : g_off
        assign gp_sample[g] = 1'b0;
        assign gp_is_in[g] = 1'b0;
      end
    end
  endgenerate

  assign gp_change = gp_is_in & (gp_sample ^ gp_last);

  // status flags; set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      gp_last <= '0;
      gp_status <= '0;
    end else if (clk_en) begin
      gp_last <= gp_sample;
      if (reg_wr && reg_addr == mpr_pkg::GPSTS_OFS) begin
        gp_status <= (gp_status & ~reg_wdata[4:0]) | gp_change; // [RULE_13]
      end else begin
        gp_status <= gp_status | gp_change; // [RULE_13]
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      multi_pin_out <= '0;
      multi_pin_oe <= '0;
      general_input <= '0;
    end else if (clk_en) begin
      multi_pin_out <= pin_drv;
      multi_pin_oe <= pin_oe; // [RULE_15]
      general_input <= gp_sample & gp_is_in;
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          mpr_pkg::ROUTE_OFS: reg_rdata <= route & mpr_pkg::ROUTE_MASK; // [RULE_08]
          mpr_pkg::GPOUT_OFS: reg_rdata <= {27'h0, gp_out_reg};
          mpr_pkg::GPIN_OFS: reg_rdata <= {27'h0, gp_sample & gp_is_in};
          mpr_pkg::GPSTS_OFS: reg_rdata <= {27'h0, gp_status};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end
endmodule // mpr_router

// >>> test/mpr_router_monitor.sv
`timescale 1ns/10ps
module mpr_router_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic global_reset_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // sources
  input wire logic [15:0] irq,
  input wire logic clock_run_line,
  input wire logic serial_interrupt_line,
  input wire logic audio_pwm_out,
  input wire logic event_output,
  input wire logic test_output_mux,
  // pins
  input wire logic [6:0] multi_pin_out,
  input wire logic [6:0] multi_pin_oe
);
  // ----------------------------------------
  // route reads and writes
  // ----------------------------------------
  // pins show a new route one edge after the strobe; checked on the third
  wire wr_rt = reg_wr && clk_en && reg_addr == mpr_pkg::ROUTE_OFS;
  wire [31:0] d = reg_wdata;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !global_reset_n);
  a_top_zero: assert property (
    reg_rd && clk_en && reg_addr == mpr_pkg::ROUTE_OFS |=> reg_rdata[31:28] == 4'h0)
    else $error("route top bits not zero");
  a_pin6_clock_run: assert property (
    wr_rt && d[27:24] == 4'h1 |-> ##3 multi_pin_oe[6] && multi_pin_out[6] == $past(clock_run_line))
    else $error("pin 6 not on clock run");
  a_pin3_serial: assert property (
    wr_rt && d[15:12] == 4'h1 |-> ##3 multi_pin_oe[3] && multi_pin_out[3] == $past(serial_interrupt_line))
    else $error("pin 3 not on serial interrupt");
  a_pin0_pwm: assert property (
    wr_rt && d[3:0] == mpr_pkg::SEL_PWM |-> ##3 multi_pin_oe[0] && multi_pin_out[0] == $past(audio_pwm_out))
    else $error("pin 0 not on pwm");
  a_pin5_event: assert property (
    wr_rt && d[23:20] == 4'hE |-> ##3 multi_pin_oe[5] && multi_pin_out[5] == $past(event_output))
    else $error("pin 5 not on event");
  a_pin2_test: assert property (
    wr_rt && d[11:8] == 4'hD |-> ##3 multi_pin_oe[2] && multi_pin_out[2] == $past(test_output_mux))
    else $error("pin 2 not on test_output_mux");
  a_pin4_irq: assert property (
    wr_rt && d[19:16] == 4'hF |-> ##3 multi_pin_oe[4] && multi_pin_out[4] == $past(irq[15]))
    else $error("pin 4 not on irq 15");
  a_pin1_quiet: assert property (
    wr_rt && d[7:4] < 4'h8 |-> ##3 !multi_pin_oe[1] [*2])
    else $error("pin 1 driven on reserved code");
endmodule // mpr_router_monitor

// >>> test/mpr_board.sv
`timescale 1ns/10ps
module mpr_board (
  // device drive
  input wire logic [6:0] multi_pin_out,
  input wire logic [6:0] multi_pin_oe,
  // board levels
  input wire logic [6:0] board_lvl,
  output logic [6:0] multi_pin_in
);
  // ----------------------------------------
  // pin resolution
  // ----------------------------------------
  // board only drives where the device lets go, so no contention
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      multi_pin_in[i] = multi_pin_oe[i] ? multi_pin_out[i] : board_lvl[i];
    end
  end
endmodule // mpr_board

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic ref_clk = 1'h0, rst_n = 1'h0, global_reset_n = 1'h0, clk_en = 1'h1;
  logic reg_wr = 1'h0, reg_rd = 1'h0, eeprom_load = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, eeprom_data = 32'h0, reg_rdata;
  logic [15:0] src = 16'h4B96;
  logic [4:0] gpo = 5'h15, general_input;
  logic [6:0] board_lvl = 7'h00, pin_in, pin_out, pin_oe;
  int bad_count = 0, samples_checked = 0;
  // one vector feeds all sources; some lines inverted to tell them apart
  mpr_router dut_u (.ref_clk, .rst_n, .global_reset_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .eeprom_load, .eeprom_data, .irq(src),
    .clock_run_line(src[1]), .serial_interrupt_line(src[0]), .pc_request_line(~src[2]),
    .video_status_line(src[6]), .video_select_0(src[7]), .audio_pwm_out(src[8]),
    .led_drive_a1(src[12]), .led_drive_a2(src[13]), .socket_led(~src[13]),
    .event_output(src[14]), .ring_indicate_output(~src[12]), .test_output_mux(~src[13]),
    .inta_line(src[2]), .multi_pin_in(pin_in), .multi_pin_out(pin_out),
    .multi_pin_oe(pin_oe), .general_input);
  mpr_board board_u (.multi_pin_out(pin_out), .multi_pin_oe(pin_oe), .board_lvl,
    .multi_pin_in(pin_in));
  initial forever #25 ref_clk = ~ref_clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // {enable, level} a pin must show for code c
  function automatic logic [1:0] pin_exp(int p, logic [3:0] c);
    logic ok;
    logic v;
    ok = c != 4'h0;
    v = src[c];
    if (p == 1) ok = c[3];
    if (p == 2) ok = ok && !(c[3] && !c[2]);
    if (p == 4 || p == 5) ok = c inside {4'h1, 4'h4, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF};
    if (p == 2 && c inside {4'h2, 4'hC, 4'hD}) v = ~v;
    if ((p == 4 && c == 4'hC) || ((p == 4 || p == 5) && c == 4'hD)) v = ~v;
    if (p == 2 && c == 4'hF) v = src[7];
    if (c == 4'h1) v = p == 6 ? src[1] : p == 3 ? src[0] : gpo[p < 3 ? p : p - 1];
    return {ok, ok & v};
  endfunction
  task automatic check_pins(input logic [31:0] rt);
    #1;
    for (int p = 0; p < 7; p++) begin
      check({30'h0, pin_oe[p], pin_out[p] & pin_oe[p]}, {30'h0, pin_exp(p, rt[4*p +: 4])});
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_default;
    rd(mpr_pkg::ROUTE_OFS, 32'h0000_1000);
    rd(8'h00, 32'h0);
    check_pins(32'h0000_1000);
  endtask
  task automatic t_codes;
    logic [31:0] rt;
    for (int c = 0; c < 16; c++) begin
      rt = {8{c[3:0]}};
      wr(mpr_pkg::ROUTE_OFS, rt);
      rd(mpr_pkg::ROUTE_OFS, rt & 32'h0FFF_FFFF);
      for (int k = 0; k < 2; k++) begin
        gpo = ~gpo;
        wr(mpr_pkg::GPOUT_OFS, {27'h0, gpo});
        src <= ~src;
        cyc(2);
        check_pins(rt);
      end
    end
  endtask
  task automatic t_resets;
    wr(mpr_pkg::ROUTE_OFS, 32'h0ABC_DEF1);
    rst_n <= 1'h0;
    cyc(2);
    rst_n <= 1'h1;
    rd(mpr_pkg::ROUTE_OFS, 32'h0ABC_DEF1);
    global_reset_n <= 1'h0;
    cyc(2);
    global_reset_n <= 1'h1;
    rd(mpr_pkg::ROUTE_OFS, 32'h0000_1000);
    rd(mpr_pkg::GPOUT_OFS, 32'h0);
    eeprom_data <= 32'hFFFF_FFFF;
    eeprom_load <= 1'h1;
    cyc(1);
    eeprom_load <= 1'h0;
    rd(mpr_pkg::ROUTE_OFS, 32'h0FFF_FFFF);
  endtask
  task automatic t_inputs;
    wr(mpr_pkg::ROUTE_OFS, 32'h0000_1000);
    cyc(4);
    wr(mpr_pkg::GPSTS_OFS, 32'h1F);
    rd(mpr_pkg::GPSTS_OFS, 32'h0);
    board_lvl <= 7'h10;
    cyc(4);
    rd(mpr_pkg::GPSTS_OFS, 32'h08);
    rd(mpr_pkg::GPIN_OFS, 32'h08);
    board_lvl <= 7'h35;
    cyc(4);
    rd(mpr_pkg::GPSTS_OFS, 32'h1D);
    check({27'h0, general_input}, 32'h1D);
  endtask
  // clock enable low: writes and pin changes must leave all state alone
  task automatic t_freeze;
    @(posedge ref_clk);
    clk_en <= 1'h0;
    wr(mpr_pkg::ROUTE_OFS, 32'h0000_0008);
    board_lvl <= 7'h00;
    cyc(4);
    #1 check({27'h0, general_input}, 32'h1D);
    check_pins(32'h0000_1000);
    clk_en <= 1'h1;
    rd(mpr_pkg::ROUTE_OFS, 32'h0000_1000);
  endtask
  initial begin
    cyc(20);
    rst_n <= 1'h1;
    global_reset_n <= 1'h1;
    t_default;
    t_codes;
    t_resets;
    t_inputs;
    t_freeze;
    complete_run;
  end
  // a hang counts as a mismatch
  initial begin
    cyc(20000);
    bad_count++;
    complete_run;
  end
endmodule // testbench
bind mpr_router mpr_router_monitor mon_u (.ref_clk, .rst_n, .global_reset_n, .clk_en,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .clock_run_line,
  .serial_interrupt_line, .audio_pwm_out, .event_output, .test_output_mux, .multi_pin_out,
  .multi_pin_oe);
